// >>> include/bsp_defines.svh
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define BSP_IR_W 4
`define BSP_OP_EXTEST 4'h0
`define BSP_OP_SAMPLE 4'h1
`define BSP_OP_IDCODE 4'h2
`define BSP_OP_CLAMP 4'h3
`define BSP_OP_HIGHZ 4'h4
`define BSP_OP_BYPASS 4'hF
`define BSP_IR_CAPTURE 4'h1

// ----------------------------------------------------------------
// Identity value layout (values arbitrary)
// ----------------------------------------------------------------
`define BSP_ID_W 32
`define BSP_ID_REV 4'hA
`define BSP_ID_PART 16'h1234
`define BSP_ID_VENDOR 11'h2A5
`define BSP_ID_MARK 1'h1

// ----------------------------------------------------------------
// Pin counts and snapshot buffer
// ----------------------------------------------------------------
`define BSP_NIN 8
`define BSP_NOUT 8
`define BSP_CHAIN_W 16
`define BSP_FIFO_D 16
`define BSP_TMS_RESET_N 3'h5
`define BSP_SYNC_RST 4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BSP_CLK_NS 10
`define BSP_TCK_MIN_NS 100
`define BSP_TCK_MIN_CYC ((`BSP_TCK_MIN_NS + `BSP_CLK_NS - 1) / `BSP_CLK_NS)

`endif

// >>> include/bsp_pkg.sv
`include "bsp_defines.svh"
`default_nettype none
package bsp_pkg;

  // Controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } bsp_state_t;

  // Boundary chain word: outputs above inputs
  typedef struct packed {
    logic [`BSP_NOUT-1:0] outs;
    logic [`BSP_NIN-1:0] ins;
  } bsp_cells_t;

endpackage
`default_nettype wire

// >>> verilog/bsp_fifo.sv
`include "bsp_defines.svh"
`default_nettype none
module bsp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(D);

  logic [W-1:0] mem_ff [D];
  logic [W-1:0] nxt_mem [D];
  logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // Handshake terms
  assign in_ready_o = (cnt_ff != (PW+1)'(D));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem_ff[rd_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointer and storage update
  always_comb
  begin
    nxt_mem = mem_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (push)
    begin
      nxt_mem[wr_ff] = in_data_i;
      nxt_wr = (wr_ff == PW'(D-1)) ? '0 : wr_ff + 1'b1;
    end
    if (pop)
      nxt_rd = (rd_ff == PW'(D-1)) ? '0 : rd_ff + 1'b1;
    if (push & ~pop)
      nxt_cnt = cnt_ff + 1'b1;
    else if (pop & ~push)
      nxt_cnt = cnt_ff - 1'b1;
  end

  // Registers
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      for (int i = 0; i < D; i++)
        mem_ff[i] <= '0;
    end
    else
    begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      mem_ff <= nxt_mem;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/bsp_tap.sv
`include "bsp_defines.svh"
`default_nettype none
module bsp_tap
  import bsp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Test port pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  // Functional pins and core side
  input wire logic [`BSP_NIN-1:0] func_in_i,
  input wire logic [`BSP_NOUT-1:0] core_out_i,
  input wire logic [`BSP_NOUT-1:0] core_oe_n_i,
  output logic [`BSP_NOUT-1:0] pin_out_o,
  output logic [`BSP_NOUT-1:0] pin_oe_n_o,
  // Boundary update snapshots
  output logic snap_valid_o,
  output bsp_cells_t snap_data_o,
  input wire logic snap_ready_i
);

  // ----------------------------------------------------------------
  // Pin synchronisers and test clock edges
  // ----------------------------------------------------------------
  logic [3:0] sync1_ff, sync2_ff;
  logic tck_d_ff;
  logic tck_s, tms_s, tdi_s, trst_n_s, rise, fall;

  // Two stages on each test pin
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      sync1_ff <= `BSP_SYNC_RST;
      sync2_ff <= `BSP_SYNC_RST;
      tck_d_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {trst_n_i, tdi_i, tms_i, tck_i};
      sync2_ff <= sync1_ff;
      tck_d_ff <= sync2_ff[0];
    end
  end

  assign tck_s = sync2_ff[0];
  assign tms_s = sync2_ff[1];
  assign tdi_s = sync2_ff[2];
  assign trst_n_s = sync2_ff[3];

  // Edge events of the test clock
  logic stall;
  assign rise = tck_s & ~tck_d_ff & ~stall;
  assign fall = ~tck_s & tck_d_ff;

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  function automatic bsp_state_t tap_next(input bsp_state_t s, input logic m);
    bsp_state_t n;
    n = ST_RESET;
    case (s)
      ST_RESET: n = m ? ST_RESET : ST_IDLE;
      ST_IDLE: n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: n = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: n = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: n = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: n = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: n = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: n = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: n = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: n = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: n = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: n = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: n = m ? ST_SEL_DR : ST_IDLE;
      default: n = ST_RESET;
    endcase
    return n;
  endfunction

  // Path selection by instruction
  function automatic logic uses_chain(input logic [`BSP_IR_W-1:0] op);
    return (op == `BSP_OP_EXTEST) || (op == `BSP_OP_SAMPLE);
  endfunction

  bsp_state_t st_ff, nxt_st;
  logic [`BSP_IR_W-1:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
  logic pass_ff, nxt_pass;
  logic [`BSP_ID_W-1:0] id_sh_ff, nxt_id_sh;
  bsp_cells_t chain_ff, nxt_chain, upd_ff, nxt_upd;
  logic push_ff, nxt_push;
  logic fifo_ready;
  logic [`BSP_ID_W-1:0] id_value;

  assign id_value = {`BSP_ID_REV, `BSP_ID_PART, `BSP_ID_VENDOR, `BSP_ID_MARK};

  // A pending push into a full snapshot buffer masks test clock rising edges
  assign stall = push_ff & ~fifo_ready;

  // Next state of controller and scan registers
  always_comb
  begin
    nxt_st = st_ff;
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    nxt_pass = pass_ff;
    nxt_id_sh = id_sh_ff;
    nxt_chain = chain_ff;
    nxt_upd = upd_ff;
    nxt_push = push_ff & ~fifo_ready;
    if (!trst_n_s)
    begin
      nxt_st = ST_RESET;
      nxt_ir = `BSP_OP_IDCODE;
    end
    else if (rise)
    begin
      nxt_st = tap_next(st_ff, tms_s);
      case (st_ff)
        ST_RESET: nxt_ir = `BSP_OP_IDCODE;
        ST_CAP_IR: nxt_ir_sh = `BSP_IR_CAPTURE;
        ST_SH_IR: nxt_ir_sh = {tdi_s, ir_sh_ff[`BSP_IR_W-1:1]};
        ST_UPD_IR: nxt_ir = ir_sh_ff;
        ST_CAP_DR:
        begin
          nxt_pass = 1'b0;
          if (ir_ff == `BSP_OP_IDCODE)
            nxt_id_sh = id_value;
          else if (uses_chain(ir_ff))
            nxt_chain = '{outs: core_out_i, ins: func_in_i};
        end
        ST_SH_DR:
        begin
          if (ir_ff == `BSP_OP_IDCODE)
            nxt_id_sh = {tdi_s, id_sh_ff[`BSP_ID_W-1:1]};
          else if (uses_chain(ir_ff))
            nxt_chain = {tdi_s, chain_ff[`BSP_CHAIN_W-1:1]};
          else
            nxt_pass = tdi_s;
        end
        ST_UPD_DR:
        begin
          if (uses_chain(ir_ff))
          begin
            nxt_upd = chain_ff;
            nxt_push = 1'b1;
          end
        end
        default: nxt_pass = pass_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      st_ff <= ST_RESET;
      ir_sh_ff <= `BSP_IR_CAPTURE;
      ir_ff <= `BSP_OP_IDCODE;
      pass_ff <= 1'b0;
      id_sh_ff <= '0;
      chain_ff <= '0;
      upd_ff <= '0;
      push_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
      pass_ff <= nxt_pass;
      id_sh_ff <= nxt_id_sh;
      chain_ff <= nxt_chain;
      upd_ff <= nxt_upd;
      push_ff <= nxt_push;
    end
  end

  // ----------------------------------------------------------------
  // Serial output on falling edges
  // ----------------------------------------------------------------
  logic tdo_ff, nxt_tdo, tdo_en_ff, nxt_tdo_en;
  logic shifting;

  assign shifting = (st_ff == ST_SH_IR) || (st_ff == ST_SH_DR);

  // Output bit of the selected path
  always_comb
  begin
    nxt_tdo = tdo_ff;
    nxt_tdo_en = tdo_en_ff;
    if (!trst_n_s)
      nxt_tdo_en = 1'b0;
    else if (fall)
    begin
      nxt_tdo_en = shifting;
      if (st_ff == ST_SH_IR)
        nxt_tdo = ir_sh_ff[0];
      else if (ir_ff == `BSP_OP_IDCODE)
        nxt_tdo = id_sh_ff[0];
      else if (uses_chain(ir_ff))
        nxt_tdo = chain_ff[0];
      else
        nxt_tdo = pass_ff;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      tdo_ff <= 1'b0;
      tdo_en_ff <= 1'b0;
    end
    else
    begin
      tdo_ff <= nxt_tdo;
      tdo_en_ff <= nxt_tdo_en;
    end
  end

  assign tdo_o = tdo_ff;
  assign tdo_oe_n_o = ~tdo_en_ff;

  // ----------------------------------------------------------------
  // Functional output control
  // ----------------------------------------------------------------
  logic forcing;
  assign forcing = (ir_ff == `BSP_OP_EXTEST) || (ir_ff == `BSP_OP_CLAMP);

  always_comb
  begin
    if (forcing)
    begin
      pin_out_o = upd_ff.outs;
      pin_oe_n_o = '0;
    end
    else if (ir_ff == `BSP_OP_HIGHZ)
    begin
      pin_out_o = core_out_i;
      pin_oe_n_o = '1;
    end
    else
    begin
      pin_out_o = core_out_i;
      pin_oe_n_o = core_oe_n_i;
    end
  end

  // ----------------------------------------------------------------
  // Snapshot buffer
  // ----------------------------------------------------------------
  bsp_fifo #(
    .W(`BSP_CHAIN_W),
    .D(`BSP_FIFO_D)
  ) u_snap (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(push_ff),
    .in_data_i(upd_ff),
    .in_ready_o(fifo_ready),
    .out_valid_o(snap_valid_o),
    .out_data_o(snap_data_o),
    .out_ready_i(snap_ready_i)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [2:0] tms_cnt_ff;
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i || !trst_n_s)
      tms_cnt_ff <= '0;
    else if (rise)
      tms_cnt_ff <= !tms_s ? 3'h0 : (tms_cnt_ff == `BSP_TMS_RESET_N) ? tms_cnt_ff
                    : tms_cnt_ff + 3'h1;
  end

  sequence s_cap_id;
    rise && st_ff == ST_CAP_DR && ir_ff == `BSP_OP_IDCODE && trst_n_s;
  endsequence

  sequence s_shift_chain;
    rise && st_ff == ST_SH_DR && uses_chain(ir_ff) && trst_n_s;
  endsequence

  a_trst_idcode: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !trst_n_s |=> st_ff == ST_RESET && ir_ff == `BSP_OP_IDCODE)
    else $error("test reset did not select identity");

  a_tms_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tms_cnt_ff == `BSP_TMS_RESET_N |-> st_ff == ST_RESET)
    else $error("five tms highs did not reach reset");

  a_id_capture: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_cap_id |=> id_sh_ff == id_value && id_sh_ff[0] == 1'b1)
    else $error("identity value not captured");

  a_sample_cap: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rise && st_ff == ST_CAP_DR && ir_ff == `BSP_OP_SAMPLE && trst_n_s
    |=> chain_ff == {$past(core_out_i), $past(func_in_i)})
    else $error("sample capture wrong");

  a_preload_shift: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_shift_chain |=> chain_ff[`BSP_CHAIN_W-1] == $past(tdi_s))
    else $error("chain did not take serial input");

  a_bypass_out: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fall && trst_n_s && st_ff == ST_SH_DR && ir_ff == `BSP_OP_BYPASS
    |=> tdo_o == $past(pass_ff) && !tdo_oe_n_o)
    else $error("bypass bit not on serial output");

  a_highz_outs: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ir_ff == `BSP_OP_HIGHZ |-> pin_oe_n_o == '1)
    else $error("outputs not floated");

  a_force_outs: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ir_ff == `BSP_OP_EXTEST || ir_ff == `BSP_OP_CLAMP)
    |-> pin_out_o == upd_ff.outs && pin_oe_n_o == '0)
    else $error("cells not forced on outputs");

  a_tdo_timing: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(tdo_oe_n_o) |-> $past(fall) && $past(shifting))
    else $error("serial output enabled off a falling edge");

endmodule
`default_nettype wire

// >>> tb/bsp_tester.sv
`default_nettype none
module bsp_tester
(
  // Bench clock
  input wire logic clk_i,
  // Test port pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o,
  input wire logic tdo_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------
  // Idle levels, test clock stands low between frames
  // ------------------------------------------------
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b1;
  end

  // One 80 ns test clock period, tdo taken mid high phase
  task automatic pulse(input logic m, input logic d, output logic o);
  begin
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    o = tdo_i;
    repeat (3) @(posedge clk_i);
    tck_o <= 1'b0;
  end
  endtask

  // Five mode-select highs reach reset, then idle
  task automatic tap_reset();
    logic o;
  begin
    repeat (5) pulse(1'b1, 1'b0, o);
    pulse(1'b0, 1'b0, o);
  end
  endtask

  // Full scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
  begin
    dout = 32'h0;
    pulse(1'b1, 1'b0, o);
    if (ir)
      pulse(1'b1, 1'b0, o);
    pulse(1'b0, 1'b0, o);
    pulse(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i], o);
      dout[i] = o;
    end
    pulse(1'b1, 1'b0, o);
    pulse(1'b0, 1'b0, o);
  end
  endtask

  // Test reset held well past the sync flops
  task automatic trst_pulse();
  begin
    @(posedge clk_i);
    trst_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    trst_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  end
  endtask
endmodule
`default_nettype wire

// >>> tb/bsp_tap_tb_top.sv
`include "bsp_defines.svh"
`default_nettype none
module bsp_tap_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe_n, snap_valid, snap_ready;
  logic [7:0] func_in, core_out, core_oe_n, pin_out, pin_oe_n;
  bsp_pkg::bsp_cells_t snap_data;
  logic [31:0] q;
  logic tdo_seen;
  int fail_count = 0;
  int num_checks = 0;
  localparam logic [31:0] id_exp = {`BSP_ID_REV, `BSP_ID_PART, `BSP_ID_VENDOR, `BSP_ID_MARK};

  // 100 MHz clock
  always #5 clk = ~clk;

  // ------------------------------------------------
  // Design and tester
  // ------------------------------------------------
  bsp_tap dut (
    .clk_i(clk), .nrst_i(nrst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .func_in_i(func_in),
    .core_out_i(core_out), .core_oe_n_i(core_oe_n), .pin_out_o(pin_out),
    .pin_oe_n_o(pin_oe_n), .snap_valid_o(snap_valid), .snap_data_o(snap_data),
    .snap_ready_i(snap_ready)
  );
  // A released serial output reads as the inverse of its last value
  assign tdo_seen = tdo_oe_n ? ~tdo : tdo;
  bsp_tester tester (
    .clk_i(clk), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo_seen)
  );

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
  begin
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task automatic check_pins(input logic [7:0] o, input logic [7:0] oe);
  begin
    @(negedge clk);
    check({24'h0, pin_out}, {24'h0, o});
    check({24'h0, pin_oe_n}, {24'h0, oe});
  end
  endtask

  // Bounded wait for a snapshot, compare, then pop it
  task automatic pop_snap(input logic [15:0] exp);
    int n;
  begin
    n = 0;
    @(negedge clk);
    while (snap_valid !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check({31'h0, snap_valid}, 32'h1);
    check({16'h0, snap_data}, {16'h0, exp});
    @(posedge clk);
    snap_ready <= 1'b1;
    @(posedge clk);
    snap_ready <= 1'b0;
  end
  endtask

  task automatic bypass_path(input logic [3:0] code);
  begin
    tester.scan(1'b1, 4, {28'h0, code}, q);
    check(q, 32'h1);
    tester.scan(1'b0, 8, 32'hB4, q);
    check(q, 32'h68);
  end
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_idcode();
  begin
    tester.tap_reset();
    tester.scan(1'b0, 32, 32'h0, q);
    check(q, id_exp);
    check_pins(core_out, core_oe_n);
    check({31'h0, tdo_oe_n}, 32'h1);
    $display("Test idcode done");
  end
  endtask

  task automatic t_sample_extest();
  begin
    tester.scan(1'b1, 4, 32'h1, q);
    check(q, 32'h1);
    tester.scan(1'b0, 16, 32'hC396, q);
    check(q, {16'h0, core_out, func_in});
    pop_snap(16'hC396);
    tester.scan(1'b1, 4, 32'h0, q);
    check_pins(8'hC3, 8'h00);
    tester.scan(1'b0, 16, 32'h1E78, q);
    check(q, {16'h0, core_out, func_in});
    pop_snap(16'h1E78);
    check_pins(8'h1E, 8'h00);
    $display("Test sample and extest done");
  end
  endtask

  task automatic t_bypass_modes();
  begin
    bypass_path(4'hF);
    check_pins(core_out, core_oe_n);
    bypass_path(4'h3);
    check_pins(8'h1E, 8'h00);
    bypass_path(4'h4);
    @(negedge clk);
    check({24'h0, pin_oe_n}, 32'hFF);
    $display("Test bypass modes done");
  end
  endtask

  // Fill the snapshot buffer while the reader stalls, then drain
  task automatic t_fifo_fill();
  begin
    tester.scan(1'b1, 4, 32'h1, q);
    for (int i = 0; i < `BSP_FIFO_D; i++)
    begin
      tester.scan(1'b0, 16, 32'h0F00 + i, q);
      check(q, {16'h0, core_out, func_in});
    end
    @(negedge clk);
    check({31'h0, snap_valid}, 32'h1);
    for (int i = 0; i < `BSP_FIFO_D; i++)
      pop_snap(16'h0F00 + i[15:0]);
    @(negedge clk);
    check({31'h0, snap_valid}, 32'h0);
    $display("Test fifo fill done");
  end
  endtask

  // Test reset in mid shift must restore identity selection
  task automatic t_test_reset();
  begin
    tester.scan(1'b1, 4, 32'hF, q);
    tester.pulse(1'b1, 1'b0, q[0]);
    tester.pulse(1'b0, 1'b0, q[0]);
    tester.pulse(1'b0, 1'b0, q[0]);
    tester.pulse(1'b0, 1'b1, q[0]);
    repeat (5) @(negedge clk);
    check({31'h0, tdo_oe_n}, 32'h0);
    tester.trst_pulse();
    @(negedge clk);
    check({31'h0, tdo_oe_n}, 32'h1);
    tester.pulse(1'b0, 1'b0, q[0]);
    tester.scan(1'b0, 32, 32'h0, q);
    check(q, id_exp);
    $display("Test test reset done");
  end
  endtask

  // ------------------------------------------------
  // Verdict
  // ------------------------------------------------
  task automatic finish_test();
  begin
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // Main sequence
  initial
  begin
    func_in = 8'h5C;
    core_out = 8'h3A;
    core_oe_n = 8'h96;
    snap_ready = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_idcode();
    t_sample_extest();
    t_bypass_modes();
    t_fifo_fill();
    t_test_reset();
    finish_test();
  end

  // Watchdog, about four times the expected run
  initial
  begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
